// ===== hw/fcp_pkg.sv
/*
  Package for the frequency counter and I/O port block: register offsets,
  field layouts, reset values, state codes and timing counts.
  Assumes a 250 MHz system clock driving every part of the block.
*/
package fcp_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_PORT     = 4'h4;
  localparam logic [3:0]  OFS_RESULT   = 4'h8;
  localparam logic [3:0]  OFS_STATUS   = 4'hC;

  // Control register layout, high bits first
  typedef struct packed {
    logic [20:0] unused;
    logic        output_choice_bit;   // bit 10
    logic        crystal_select;      // bit 9
    logic        period_input_enable; // bit 8
    logic        high_band_input_enable; // bit 7
    logic        low_band_input_enable;  // bit 6
    logic [2:0]  count_mode_select;   // bits 5:3
    logic        start;               // bit 2
    logic [1:0]  gate_select;         // bits 1:0
  } fcp_ctrl_t;

  // Port register field positions
  localparam int PORT_OUT_LSB = 0;    // output_pin_bits 3:0
  localparam int PORT_DIR_LSB = 4;    // port_direction_bits 8:4
  localparam int PORT_DAT_LSB = 9;    // port_output_bits 13:9
  localparam int NUM_OUT      = 4;
  localparam int NUM_IO       = 5;

  // Status register field positions
  localparam int STAT_BUSY    = 0;
  localparam int STAT_WRAP    = 1;
  localparam int STAT_PIN_LSB = 2;

  // Shared pin positions inside the bidirectional port
  localparam int PIN_PERIOD   = 2;
  localparam int PIN_HIGH     = 3;
  localparam int PIN_LOW      = 4;

  // Reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [13:0] PORT_RESET  = 14'h0000;

  // Gate and mode codes
  localparam logic [1:0]  GATE_MANUAL = 2'h3;
  localparam logic [2:0]  MODE_LOW0   = 3'h0;
  localparam logic [2:0]  MODE_LOW1   = 3'h1;
  localparam logic [2:0]  MODE_MID    = 3'h2;
  localparam logic [2:0]  MODE_HIGH   = 3'h3;
  localparam logic [2:0]  MODE_PERIOD = 3'h7;
  localparam logic [1:0]  PRESCALE_LAST = 2'h3;

  // Measurement states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_GATE   = 3'b001,
    ST_MANUAL = 3'b010,
    ST_PWAIT  = 3'b011,
    ST_PCOUNT = 3'b100
  } fcp_state_t;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS       = 4;
  localparam int GATE_1MS_NS  = 1000000;
  localparam int GATE_4MS_NS  = 4000000;
  localparam int GATE_16MS_NS = 16000000;
  localparam int GATE_1MS_CYC  = GATE_1MS_NS / CLK_NS;
  localparam int GATE_4MS_CYC  = GATE_4MS_NS / CLK_NS;
  localparam int GATE_16MS_CYC = GATE_16MS_NS / CLK_NS;
  localparam int PULSE_20US_NS = 20000;
  localparam int PULSE_6U6_NS  = 6600;
  localparam int PULSE_1U1_NS  = 1100;
  localparam int PULSE_20US_CYC = PULSE_20US_NS / CLK_NS;
  localparam int PULSE_6U6_CYC  = PULSE_6U6_NS / CLK_NS;
  localparam int PULSE_1U1_CYC  = PULSE_1U1_NS / CLK_NS;
  localparam int XTAL_LO_KHZ   = 4500;
  localparam int XTAL_HI_KHZ   = 7200;
  localparam int XTAL_LO_CYC   = 1000000 / (XTAL_LO_KHZ * CLK_NS);
  localparam int XTAL_HI_CYC   = 1000000 / (XTAL_HI_KHZ * CLK_NS);
  localparam int TMR_W         = 22;
  localparam int PUL_W         = 13;

endpackage

// ===== hw/fcp_top.sv
/*
  Frequency / period counter with general purpose output and I/O port.
  Assumes registers are reached over a plain strobe port on CLK_SYS and
  that all pins arrive asynchronously and are resynchronised here.
*/
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Frequency mode counts selected input edges during a fixed gate.
// - Period mode counts measurement pulses over one period-pin period.
// - Gate select picks gate time and period pulse; 11 is manual.
// - Manual gate counts while start is 1; host keeps it two transfers.
// - Manual counting begins and ends on the write that changes start.
// - Every write with start set begins a new measurement.
// - Mode field selects low, mid, high band or period input.
// - Mode with upper 1, middle 0 turns phase_out_2 into fourth output.
// - High band input is divided by four in high mode; mid mode counts it undivided.
// - Input enable bits turn shared pins into counter inputs.
// - Result reads back in binary; output choice must be 0.
// - Busy is 1 during a measurement and 0 once finished.
// - Output pin bits drive the dedicated outputs in parallel.
// - Direction bit 0 makes a port pin input, 1 output.
// - Port pin levels are returned to the host as port input bits.
// - Port pin levels are latched at the transfer that reads them.
// - Output-mode port pins drive their port output bits.
// - Reset clears direction and output bits: inputs, outputs low.
// - Crystal select picks 4.5 or 7.2 MHz rate for manual pulses.
module fcp_top #(
  parameter int GATE_1MS  = fcp_pkg::GATE_1MS_CYC,
  parameter int GATE_4MS  = fcp_pkg::GATE_4MS_CYC,
  parameter int GATE_16MS = fcp_pkg::GATE_16MS_CYC,
  parameter int PULSE_20US = fcp_pkg::PULSE_20US_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [31:0] RDATA,
  input  wire logic [4:0]  BIDIR_PORT_IN,
  output var  logic [4:0]  BIDIR_PORT_OUT,
  output var  logic [4:0]  BIDIR_PORT_OE,
  output var  logic [3:0]  DEDICATED_OUTPUT_PINS,
  output var  logic        PHASE_OUT_2,
  output var  logic        PHASE_OUT_2_OE
);

  // ------------------------------------------------------------
  // Registers and synchronisers
  // ------------------------------------------------------------
  fcp_pkg::fcp_ctrl_t      ctrl_q;
  logic [13:0]             port_q;
  logic [4:0]              pin_s1_q;
  logic [4:0]              pin_s2_q;
  logic [4:0]              pin_s3_q;
  logic [15:0]             count_q;
  logic                    wrap_q;
  logic                    busy_q;
  fcp_pkg::fcp_state_t     state_q;
  logic [fcp_pkg::TMR_W-1:0] timer_q;
  logic [fcp_pkg::PUL_W-1:0] pul_q;
  logic [1:0]              pre_q;
  logic                    wr_ctrl;
  logic                    start_wr;
  logic                    stop_wr;
  logic [2:0]              mode;
  logic                    freq_edge;
  logic                    per_edge;
  logic                    pulse_tick;
  logic                    count_en;
  logic [fcp_pkg::TMR_W-1:0] gate_len;
  logic [fcp_pkg::PUL_W-1:0] pul_len;
  logic [4:0]              pin_rise;

  // Decoded write events
  assign wr_ctrl  = WR && (ADDR == fcp_pkg::OFS_CTRL);
  assign start_wr = wr_ctrl && WDATA[2];
  assign stop_wr  = wr_ctrl && !WDATA[2];
  assign mode     = ctrl_q.count_mode_select;
  assign pin_rise = pin_s2_q & ~pin_s3_q;

  // Control register write
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= fcp_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      port_q <= fcp_pkg::PORT_RESET;
    end else if (WR && (ADDR == fcp_pkg::OFS_PORT)) begin
      port_q <= WDATA[13:0];
    end
  end

  // Two-stage pin synchroniser plus a delay stage for edge finding
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pin_s1_q <= 5'h0;
      pin_s2_q <= 5'h0;
      pin_s3_q <= 5'h0;
    end else begin
      pin_s1_q <= BIDIR_PORT_IN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ------------------------------------------------------------
  // Counter input selection
  // ------------------------------------------------------------
  // mode picks the input
  always_comb begin
    freq_edge = 1'b0;
    unique case (mode)
      fcp_pkg::MODE_LOW0, fcp_pkg::MODE_LOW1:
        freq_edge = pin_rise[fcp_pkg::PIN_LOW] && ctrl_q.low_band_input_enable;
      fcp_pkg::MODE_MID:
        freq_edge = pin_rise[fcp_pkg::PIN_HIGH] &&
                    ctrl_q.high_band_input_enable;
      fcp_pkg::MODE_HIGH:
        freq_edge = pin_rise[fcp_pkg::PIN_HIGH] &&
                    ctrl_q.high_band_input_enable &&
                    (pre_q == fcp_pkg::PRESCALE_LAST);
      default:
        freq_edge = 1'b0;
    endcase
  end

  assign per_edge = pin_rise[fcp_pkg::PIN_PERIOD] &&
                    ctrl_q.period_input_enable;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pre_q <= 2'h0;
    end else if (start_wr) begin
      pre_q <= 2'h0;
    end else if (pin_rise[fcp_pkg::PIN_HIGH] &&
                 ctrl_q.high_band_input_enable) begin
      pre_q <= pre_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Time base: gate length and period measurement pulses
  // ------------------------------------------------------------
  // gate and pulse choice
  always_comb begin
    gate_len = fcp_pkg::TMR_W'(GATE_1MS);
    pul_len  = fcp_pkg::PUL_W'(PULSE_20US);
    unique case (ctrl_q.gate_select)
      2'h0: begin
        gate_len = fcp_pkg::TMR_W'(GATE_1MS);
        pul_len  = fcp_pkg::PUL_W'(PULSE_20US);
      end
      2'h1: begin
        gate_len = fcp_pkg::TMR_W'(GATE_4MS);
        pul_len  = fcp_pkg::PUL_W'(fcp_pkg::PULSE_6U6_CYC);
      end
      2'h2: begin
        gate_len = fcp_pkg::TMR_W'(GATE_16MS);
        pul_len  = fcp_pkg::PUL_W'(fcp_pkg::PULSE_1U1_CYC);
      end
      2'h3: begin
        gate_len = fcp_pkg::TMR_W'(GATE_1MS);
        pul_len  = ctrl_q.crystal_select ?
                   fcp_pkg::PUL_W'(fcp_pkg::XTAL_HI_CYC) :
                   fcp_pkg::PUL_W'(fcp_pkg::XTAL_LO_CYC);
      end
    endcase
  end

  // Pulse divider, restarted with each measurement
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pul_q <= '0;
    end else if (start_wr || pulse_tick) begin
      pul_q <= '0;
    end else begin
      pul_q <= pul_q + 1'b1;
    end
  end
  assign pulse_tick = (pul_q == pul_len - 1'b1);

  // Gate timer runs only in the timed gate state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      timer_q <= '0;
    end else if (start_wr) begin
      timer_q <= '0;
    end else if (state_q == fcp_pkg::ST_GATE) begin
      timer_q <= timer_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Measurement sequencer
  // ------------------------------------------------------------
  // timed gate, manual gate and period states
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_q <= fcp_pkg::ST_IDLE;
    end else if (start_wr) begin
      if (WDATA[5:3] == fcp_pkg::MODE_PERIOD) begin
        state_q <= fcp_pkg::ST_PWAIT;
      end else if (WDATA[1:0] == fcp_pkg::GATE_MANUAL) begin
        state_q <= fcp_pkg::ST_MANUAL;
      end else begin
        state_q <= fcp_pkg::ST_GATE;
      end
    end else begin
      unique case (state_q)
        fcp_pkg::ST_IDLE: begin
          state_q <= fcp_pkg::ST_IDLE;
        end
        fcp_pkg::ST_GATE: begin
          if (timer_q == gate_len - 1'b1) begin
            state_q <= fcp_pkg::ST_IDLE;
          end
        end
        fcp_pkg::ST_MANUAL: begin
          if (stop_wr) begin
            state_q <= fcp_pkg::ST_IDLE;
          end
        end
        fcp_pkg::ST_PWAIT: begin
          if (per_edge) begin
            state_q <= fcp_pkg::ST_PCOUNT;
          end
        end
        fcp_pkg::ST_PCOUNT: begin
          if (per_edge) begin
            state_q <= fcp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= fcp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Count enables per state
  always_comb begin
    count_en = 1'b0;
    if ((state_q == fcp_pkg::ST_GATE) || (state_q == fcp_pkg::ST_MANUAL)) begin
      count_en = freq_edge;
    end else if (state_q == fcp_pkg::ST_PCOUNT) begin
      count_en = pulse_tick && !per_edge;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      count_q <= 16'h0000;
      wrap_q  <= 1'b0;
    end else if (start_wr) begin
      count_q <= 16'h0000;
      wrap_q  <= 1'b0;
    end else if (count_en && !stop_wr) begin
      count_q <= count_q + 16'h0001;
      if (count_q == 16'hFFFF) begin
        wrap_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= start_wr || (state_q != fcp_pkg::ST_IDLE &&
                !(state_q == fcp_pkg::ST_MANUAL && stop_wr));
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // dedicated outputs
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      DEDICATED_OUTPUT_PINS <= 4'h0;
      PHASE_OUT_2           <= 1'b0;
      PHASE_OUT_2_OE        <= 1'b0;
    end else begin
      DEDICATED_OUTPUT_PINS <= port_q[fcp_pkg::PORT_OUT_LSB +: fcp_pkg::NUM_OUT];
      PHASE_OUT_2           <= port_q[fcp_pkg::PORT_OUT_LSB + 3];
      PHASE_OUT_2_OE        <= mode[2] && !mode[1];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      BIDIR_PORT_OUT <= 5'h0;
      BIDIR_PORT_OE  <= 5'h0;
    end else begin
      BIDIR_PORT_OUT <= port_q[fcp_pkg::PORT_DAT_LSB +: fcp_pkg::NUM_IO];
      BIDIR_PORT_OE  <= port_q[fcp_pkg::PORT_DIR_LSB +: fcp_pkg::NUM_IO] &
                        ~{ctrl_q.low_band_input_enable,
                          ctrl_q.high_band_input_enable,
                          ctrl_q.period_input_enable, 2'b00};
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // binary result
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        fcp_pkg::OFS_CTRL:   RDATA <= ctrl_q;
        fcp_pkg::OFS_PORT:   RDATA <= {18'h0_0000, port_q};
        fcp_pkg::OFS_RESULT: RDATA <= ctrl_q.output_choice_bit ?
                                      32'h0000_0000 : {16'h0000, count_q};
        fcp_pkg::OFS_STATUS: RDATA <= {25'h000_0000, pin_s2_q,
                                       wrap_q, busy_q};
        default:             RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ===== verification/fcp_props.sv
/*
  Port checker for the counter and I/O port block.
  Assumes it is bound into fcp_top, one clock CLK_SYS, reset RESET.
*/
`timescale 1ns/1ns
`default_nettype none

module fcp_props (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [4:0]  BIDIR_PORT_IN,
  input wire logic [4:0]  BIDIR_PORT_OUT,
  input wire logic [4:0]  BIDIR_PORT_OE,
  input wire logic [3:0]  DEDICATED_OUTPUT_PINS,
  input wire logic        PHASE_OUT_2,
  input wire logic        PHASE_OUT_2_OE
);
  logic [10:0] ctl_q;
  logic [13:0] prt_q;
  logic [1:0]  qc_q;
  logic [4:0]  oe_x;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // Mirror of the control and port registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctl_q <= 11'h000;
      prt_q <= 14'h0000;
    end else if (WR && ADDR == fcp_pkg::OFS_CTRL) begin
      ctl_q <= WDATA[10:0];
    end else if (WR && ADDR == fcp_pkg::OFS_PORT) begin
      prt_q <= WDATA[13:0];
    end
  end

  // Cycles since the last write, saturating at three
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      qc_q <= 2'h0;
    end else if (WR) begin
      qc_q <= 2'h0;
    end else if (qc_q != 2'h3) begin
      qc_q <= qc_q + 2'h1;
    end
  end

  // Shared pins handed to the counter are never driven
  assign oe_x = prt_q[8:4] & ~{ctl_q[6], ctl_q[7], ctl_q[8], 2'b00};

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_reset_clear: assert property (
    $fell(RESET) |-> BIDIR_PORT_OE == 5'h00 && BIDIR_PORT_OUT == 5'h00
      && DEDICATED_OUTPUT_PINS == 4'h0)
    else $error("outputs not clear after reset");
  a_rdata_idle: assert property (
    !$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data outside read slot");
  a_out_write: assert property (
    WR && ADDR == fcp_pkg::OFS_PORT
    |-> ##2 DEDICATED_OUTPUT_PINS == $past(WDATA[3:0], 2))
    else $error("dedicated outputs not updated");
  a_port_dir: assert property (
    qc_q == 2'h3 |-> BIDIR_PORT_OE == oe_x)
    else $error("port enable wrong");
  a_port_drive: assert property (
    qc_q == 2'h3 |-> BIDIR_PORT_OUT == prt_q[13:9] && PHASE_OUT_2 == prt_q[3])
    else $error("port drive wrong");
  a_phase_mode: assert property (
    qc_q == 2'h3 |-> PHASE_OUT_2_OE == (ctl_q[5] & ~ctl_q[4]))
    else $error("fourth output enable wrong");
  a_result_hide: assert property (
    RD && ADDR == fcp_pkg::OFS_RESULT && ctl_q[10] |=> RDATA == 32'h0000_0000)
    else $error("result visible with choice bit set");
  a_pins_seen: assert property (
    RD && ADDR == fcp_pkg::OFS_STATUS && !$past(RESET, 4)
      && $past(BIDIR_PORT_IN, 1) == BIDIR_PORT_IN
      && $past(BIDIR_PORT_IN, 2) == BIDIR_PORT_IN
      && $past(BIDIR_PORT_IN, 3) == BIDIR_PORT_IN
    |=> RDATA[6:2] == $past(BIDIR_PORT_IN))
    else $error("pin levels read wrong");

  c_start: cover property (WR && ADDR == fcp_pkg::OFS_CTRL && WDATA[2]);
  c_period: cover property (WR && WDATA[5:3] == 3'h7 && WDATA[2]);
  c_manual_end: cover property (WR && ctl_q[1:0] == 2'h3 && !WDATA[2]);
endmodule

`default_nettype wire

// ===== verification/fcp_pin_model.sv
/*
  Far side of the pins: a link clock on the counter pins and pull-downs.
  Assumes the bench raises run only while a measurement is wanted.
*/
`timescale 1ns/1ns
`default_nettype none

module fcp_pin_model (
  input  wire logic       run,
  input  wire logic [4:0] oe,
  input  wire logic [4:0] out,
  output var  logic [4:0] lvl
);
  logic lk;

  // Link clock of 160 ns, held low between measurements
  initial begin
    lk = 1'b0;
    #1;
    forever begin
      #80;
      lk = run ? ~lk : 1'b0;
    end
  end

  // Wire level: driven pins follow the block, else link clock or pull-down
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      lvl[i] = oe[i] ? out[i] : ((i >= 2) ? lk : 1'b0);
    end
  end
endmodule

`default_nettype wire

// ===== verification/tb.sv
/*
  Self-checking bench for the counter and I/O port block.
  Assumes fcp_pkg, fcp_top, fcp_pin_model and fcp_props compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        clk;
  logic        rst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        run;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [4:0]  pin_in;
  logic [4:0]  p_out;
  logic [4:0]  p_oe;
  logic [3:0]  ded;
  logic        ph;
  logic        ph_oe;
  int          n_fail;
  int          checks;
  logic [31:0] cfg [10];
  int          lo [10];
  int          hi [10];

  fcp_top #(.GATE_1MS(400), .GATE_4MS(800), .GATE_16MS(1600),
            .PULSE_20US(20)) u_dut (
    .CLK_SYS               (clk),
    .RESET                 (rst),
    .ADDR                  (addr),
    .WDATA                 (wdata),
    .WR                    (wr),
    .RD                    (rd),
    .RDATA                 (rdata),
    .BIDIR_PORT_IN         (pin_in),
    .BIDIR_PORT_OUT        (p_out),
    .BIDIR_PORT_OE         (p_oe),
    .DEDICATED_OUTPUT_PINS (ded),
    .PHASE_OUT_2           (ph),
    .PHASE_OUT_2_OE        (ph_oe)
  );

  fcp_pin_model u_pins (.run(run), .oe(p_oe), .out(p_out), .lvl(pin_in));

  // Clock of 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog for a hung run
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    results();
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int l, input int h);
    checks++;
    if ($isunknown(got) || got < 32'(l) || got > 32'(h)) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, l, h);
    end
  endtask

  // Start a measurement, wait for busy to drop, check the count
  task automatic measure(input logic [31:0] c, input int l, input int h);
    int n;
    wr_reg(fcp_pkg::OFS_CTRL, c);
    run <= 1'b1;
    rd_reg(fcp_pkg::OFS_STATUS, d);
    chk(d & 32'h0000_0001, 32'h0000_0001);
    n = 0;
    while (d[0] !== 1'b0 && n < 1000) begin
      rd_reg(fcp_pkg::OFS_STATUS, d);
      n++;
    end
    run <= 1'b0;
    chk(d & 32'h0000_0003, 32'h0000_0000);
    rd_reg(fcp_pkg::OFS_RESULT, d);
    chk_rng(d, l, h);
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    run = 1'b0;
    cfg = '{32'h0000_0044, 32'h0000_0045, 32'h0000_0046, 32'h0000_004C,
            32'h0000_0094, 32'h0000_009E, 32'h0000_0004, 32'h0000_013C,
            32'h0000_013F, 32'h0000_033F};
    lo = '{9, 19, 39, 9, 9, 9, 0, 1, 0, 1};
    hi = '{11, 21, 41, 11, 11, 11, 0, 3, 1, 2};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({16'h0000, ded, p_oe, p_out, ph, ph_oe}, 32'h0000_0000);
    rd_reg(fcp_pkg::OFS_CTRL, d);
    chk(d, 32'h0000_0000);
    rd_reg(4'h2, d);
    chk(d, 32'h0000_0000);
    $display("test reset done");
    // Outputs, directions, and a shared pin kept for the counter
    wr_reg(fcp_pkg::OFS_CTRL, 32'h0000_0040);
    wr_reg(fcp_pkg::OFS_PORT, 32'h0000_2BFA);
    repeat (4) @(posedge clk);
    chk({28'h0, ded}, 32'h0000_000A);
    chk({27'h0, p_oe}, 32'h0000_000F);
    chk({27'h0, p_out}, 32'h0000_0015);
    chk({30'h0, ph_oe, ph}, 32'h0000_0001);
    rd_reg(fcp_pkg::OFS_STATUS, d);
    chk(d & 32'h0000_007F, 32'h0000_0014);
    wr_reg(fcp_pkg::OFS_PORT, 32'h0000_0000);
    $display("test port done");
    // Every mode code and the fourth output switch
    for (int c = 0; c < 8; c++) begin
      wr_reg(fcp_pkg::OFS_CTRL, 32'(c) << 3);
      repeat (3) @(posedge clk);
      chk({31'h0, ph_oe}, {31'h0, c[2] & ~c[1]});
    end
    $display("test modes done");
    // Gates, bands, prescaler, period and crystal rates
    for (int i = 0; i < 10; i++) begin
      measure(cfg[i], lo[i], hi[i]);
    end
    $display("test measure done");
    // Manual gate opened and closed by writes
    wr_reg(fcp_pkg::OFS_CTRL, 32'h0000_0047);
    run <= 1'b1;
    repeat (800) @(posedge clk);
    rd_reg(fcp_pkg::OFS_STATUS, d);
    chk(d & 32'h0000_0001, 32'h0000_0001);
    wr_reg(fcp_pkg::OFS_CTRL, 32'h0000_0043);
    run <= 1'b0;
    rd_reg(fcp_pkg::OFS_STATUS, d);
    chk(d & 32'h0000_0003, 32'h0000_0000);
    rd_reg(fcp_pkg::OFS_RESULT, d);
    chk_rng(d, 19, 22);
    $display("test manual done");
    // Restart while busy, then hide the result
    wr_reg(fcp_pkg::OFS_CTRL, 32'h0000_0046);
    run <= 1'b1;
    repeat (600) @(posedge clk);
    measure(32'h0000_0044, 9, 11);
    wr_reg(fcp_pkg::OFS_CTRL, 32'h0000_0400);
    rd_reg(fcp_pkg::OFS_RESULT, d);
    chk(d, 32'h0000_0000);
    $display("test restart done");
    results();
  end
endmodule

bind fcp_top fcp_props u_props (
  .CLK_SYS               (CLK_SYS),
  .RESET                 (RESET),
  .ADDR                  (ADDR),
  .WDATA                 (WDATA),
  .WR                    (WR),
  .RD                    (RD),
  .RDATA                 (RDATA),
  .BIDIR_PORT_IN         (BIDIR_PORT_IN),
  .BIDIR_PORT_OUT        (BIDIR_PORT_OUT),
  .BIDIR_PORT_OE         (BIDIR_PORT_OE),
  .DEDICATED_OUTPUT_PINS (DEDICATED_OUTPUT_PINS),
  .PHASE_OUT_2           (PHASE_OUT_2),
  .PHASE_OUT_2_OE        (PHASE_OUT_2_OE)
);

`default_nettype wire
